// *** src/eeprom_seq_pkg.sv ***
// Constants and types for the serial EEPROM read-side slave.
// Assumes one bus master drives the serial clock; data line is open drain.
// Notes on behaviour
// - Acknowledge a matching 7-bit device address with read bit 1 after a start.
// - Shift each read byte out as 8 bits, timed by the master's serial clock.
// - During reads, increment the address counter on the falling edge ending bit 8.
// - Master acknowledge continues the read with the byte at the next address.
// - Master no-acknowledge then stop ends the read operation.
// - During reads, the address counter wraps from the last word address to the first.
// - During writes, increment the low PAGE_BITS counter bits on the falling edge ending bit 8.
// - Drive the acknowledge during the 9th clock of a matching address byte.
// - Keep the address after the last accessed byte; a current-address read starts there.
// - Dummy write: word address after write-type address loads the counter.
package eeprom_seq_pkg;

  localparam int        ADDR_W_DEF    = 8;
  localparam int        PAGE_BITS_DEF = 3;
  // Value is arbitrary
  localparam logic [6:0] DEV_ADDR_DEF = 7'h2D;
  localparam logic [2:0] BIT_LAST     = 3'h7;
  localparam logic [2:0] BIT_FIRST    = 3'h0;
  localparam logic [2:0] BIT_SECOND   = 3'h1;

  typedef enum logic [3:0] {
    ST_IDLE     = 4'b0000,
    ST_DEV      = 4'b0001,
    ST_DEV_ACK  = 4'b0010,
    ST_WADDR    = 4'b0011,
    ST_WADDR_ACK = 4'b0100,
    ST_WDATA    = 4'b0101,
    ST_WDATA_ACK = 4'b0110,
    ST_RDATA    = 4'b0111,
    ST_RDATA_ACK = 4'b1000
  } link_state_t;

endpackage

// *** src/eeprom_seq_read.sv ***
// Serial EEPROM slave: address counter, sequential read and write capture.
// Assumes scl_i is a clean clock from the master; sda is open drain outside.
`timescale 1ns/1ps
module eeprom_seq_read
  import eeprom_seq_pkg::*;
#(
  parameter int         ADDR_W    = ADDR_W_DEF,
  parameter int         PAGE_BITS = PAGE_BITS_DEF,
  parameter logic [6:0] DEV_ADDR  = DEV_ADDR_DEF
) (
  // System clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // Serial link
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe,
  // Status in system clock domain
  output logic      read_busy,
  output logic      read_byte_done
);

  localparam int DEPTH = 1 << ADDR_W;

  link_state_t       state_q;
  logic [2:0]        cnt_q;
  logic [7:0]        sh_q;
  logic              rw_q;
  logic              start_tog_q;
  logic              stop_tog_q;
  logic              start_seen_q;
  logic              stop_seen_q;
  logic              busy_q;
  logic              byte_tog_q;
  logic              oe_q;
  logic              sda_o_q;
  logic [7:0]        tx_q;
  logic [ADDR_W-1:0] addr_q;
  logic [7:0]        mem_q [DEPTH];
  logic [7:0]        rx_byte;
  logic              start_pend;
  logic              stop_pend;
  logic              busy_s1_q;
  logic              busy_s2_q;
  logic              read_busy_q;
  logic              tog_s1_q;
  logic              tog_s2_q;
  logic              tog_s3_q;
  logic              byte_done_q;

  assign rx_byte    = {sh_q[6:0], sda_i};
  assign start_pend = start_tog_q != start_seen_q;
  assign stop_pend  = stop_tog_q != stop_seen_q;

  // Start: data falls while clock high
  always_ff @(negedge sda_i or posedge rst) begin
    if (rst) begin
      start_tog_q <= 1'b0;
    end else if (scl_i) begin
      start_tog_q <= ~start_tog_q;
    end
  end

  // Stop: data rises while clock high
  always_ff @(posedge sda_i or posedge rst) begin
    if (rst) begin
      stop_tog_q <= 1'b0;
    end else if (scl_i) begin
      stop_tog_q <= ~stop_tog_q;
    end
  end

  // Bit sampling and sequencing on the rising clock edge
  always_ff @(posedge scl_i or posedge rst) begin
    if (rst) begin
      state_q      <= ST_IDLE;
      cnt_q        <= BIT_FIRST;
      sh_q         <= 8'h00;
      rw_q         <= 1'b0;
      start_seen_q <= 1'b0;
      stop_seen_q  <= 1'b0;
      busy_q       <= 1'b0;
      byte_tog_q   <= 1'b0;
    end else begin
      start_seen_q <= start_tog_q;
      stop_seen_q  <= stop_tog_q;
      if (start_pend) begin
        state_q <= ST_DEV;
        cnt_q   <= BIT_SECOND;
        sh_q    <= {7'h00, sda_i};
        busy_q  <= 1'b0;
      end else if (stop_pend) begin
        state_q <= ST_IDLE;
        busy_q  <= 1'b0;
      end else begin
        case (state_q)
          ST_DEV: begin
            sh_q  <= rx_byte;
            cnt_q <= cnt_q + 3'h1;
            if (cnt_q == BIT_LAST) begin
              if (rx_byte[7:1] == DEV_ADDR) begin
                state_q <= ST_DEV_ACK;
                rw_q    <= rx_byte[0];
              end else begin
                state_q <= ST_IDLE;
              end
            end
          end
          ST_DEV_ACK: begin
            cnt_q   <= BIT_FIRST;
            state_q <= rw_q ? ST_RDATA : ST_WADDR;
            busy_q  <= rw_q;
          end
          ST_WADDR, ST_WDATA: begin
            sh_q  <= rx_byte;
            cnt_q <= cnt_q + 3'h1;
            if (cnt_q == BIT_LAST) begin
              state_q <= (state_q == ST_WADDR) ? ST_WADDR_ACK : ST_WDATA_ACK;
            end
          end
          ST_WADDR_ACK, ST_WDATA_ACK: begin
            cnt_q   <= BIT_FIRST;
            state_q <= ST_WDATA;
          end
          ST_RDATA: begin
            cnt_q <= cnt_q + 3'h1;
            if (cnt_q == BIT_LAST) begin
              state_q <= ST_RDATA_ACK;
            end
          end
          ST_RDATA_ACK: begin
            cnt_q      <= BIT_FIRST;
            byte_tog_q <= ~byte_tog_q;
            if (!sda_i) begin
              state_q <= ST_RDATA;
            end else begin
              state_q <= ST_IDLE;
              busy_q  <= 1'b0;
            end
          end
          default: begin
            state_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // Data line drive and address counter on the falling clock edge
  always_ff @(negedge scl_i or posedge rst) begin
    if (rst) begin
      oe_q    <= 1'b0;
      sda_o_q <= 1'b0;
      tx_q    <= 8'h00;
      addr_q  <= '0;
    end else begin
      sda_o_q <= 1'b0;
      case (state_q)
        ST_DEV_ACK: begin
          oe_q <= 1'b1;
        end
        ST_WADDR_ACK: begin
          oe_q   <= 1'b1;
          addr_q <= sh_q[ADDR_W-1:0];
        end
        ST_WDATA_ACK: begin
          oe_q           <= 1'b1;
          mem_q[addr_q]  <= sh_q;
          addr_q[PAGE_BITS-1:0] <= addr_q[PAGE_BITS-1:0] + 1'b1;
        end
        ST_RDATA: begin
          if (cnt_q == BIT_FIRST) begin
            oe_q <= ~mem_q[addr_q][7];
            tx_q <= {mem_q[addr_q][6:0], 1'b0};
          end else begin
            oe_q <= ~tx_q[7];
            tx_q <= {tx_q[6:0], 1'b0};
          end
        end
        ST_RDATA_ACK: begin
          oe_q   <= 1'b0;
          addr_q <= addr_q + 1'b1;
        end
        default: begin
          oe_q <= 1'b0;
        end
      endcase
    end
  end

  // Status crossing into the system clock domain
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      busy_s1_q   <= 1'b0;
      busy_s2_q   <= 1'b0;
      read_busy_q <= 1'b0;
      tog_s1_q    <= 1'b0;
      tog_s2_q    <= 1'b0;
      tog_s3_q    <= 1'b0;
      byte_done_q <= 1'b0;
    end else begin
      busy_s1_q   <= busy_q;
      busy_s2_q   <= busy_s1_q;
      read_busy_q <= busy_s2_q;
      tog_s1_q    <= byte_tog_q;
      tog_s2_q    <= tog_s1_q;
      tog_s3_q    <= tog_s2_q;
      byte_done_q <= tog_s2_q ^ tog_s3_q;
    end
  end

  assign sda_o          = sda_o_q;
  assign sda_oe         = oe_q;
  assign read_busy      = read_busy_q;
  assign read_byte_done = byte_done_q;

  property p_dev_ack_read;
    @(posedge scl_i) disable iff (rst)
      (state_q == ST_DEV && cnt_q == BIT_LAST && !start_pend && !stop_pend
       && rx_byte[7:1] == DEV_ADDR && rx_byte[0]) |=> (state_q == ST_DEV_ACK && rw_q);
  endproperty
  a_dev_ack_read: assert property (p_dev_ack_read) else $error("read address not taken");

  property p_ack_driven;
    @(posedge scl_i) disable iff (rst)
      (state_q == ST_DEV_ACK) |-> oe_q;
  endproperty
  a_ack_driven: assert property (p_ack_driven) else $error("address ack not driven");

  property p_first_bit;
    @(posedge scl_i) disable iff (rst)
      (state_q == ST_RDATA && cnt_q == BIT_FIRST) |-> (oe_q == ~mem_q[addr_q][7]);
  endproperty
  a_first_bit: assert property (p_first_bit) else $error("first read bit wrong");

  property p_read_incr;
    @(posedge scl_i) disable iff (rst)
      (state_q == ST_RDATA_ACK) |-> (addr_q == ADDR_W'($past(addr_q) + 1'b1));
  endproperty
  a_read_incr: assert property (p_read_incr) else $error("read counter not advanced");

  property p_wrap;
    @(posedge scl_i) disable iff (rst)
      (state_q == ST_RDATA_ACK && $past(addr_q) == {ADDR_W{1'b1}}) |-> (addr_q == '0);
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter did not wrap");

  property p_continue;
    @(posedge scl_i) disable iff (rst)
      (state_q == ST_RDATA_ACK && !sda_i && !start_pend && !stop_pend)
        |=> (state_q == ST_RDATA && cnt_q == BIT_FIRST) ##1 (state_q == ST_RDATA);
  endproperty
  a_continue: assert property (p_continue) else $error("burst did not continue");

  property p_nack_release;
    @(posedge scl_i) disable iff (rst)
      (state_q == ST_RDATA_ACK && sda_i && !start_pend && !stop_pend)
        |-> !oe_q ##1 (state_q == ST_IDLE && !busy_q);
  endproperty
  a_nack_release: assert property (p_nack_release) else $error("nack not honoured");

  property p_stop_ends;
    @(posedge scl_i) disable iff (rst)
      stop_pend |=> (!busy_q
        && state_q == ($past(start_pend) ? ST_DEV : ST_IDLE));
  endproperty
  a_stop_ends: assert property (p_stop_ends) else $error("stop did not end read");

  property p_word_load;
    @(posedge scl_i) disable iff (rst)
      (state_q == ST_WADDR_ACK) |=> (addr_q == $past(sh_q[ADDR_W-1:0]));
  endproperty
  a_word_load: assert property (p_word_load) else $error("word address not loaded");

  property p_write_incr;
    @(posedge scl_i) disable iff (rst)
      (state_q == ST_WDATA_ACK) |-> (addr_q[PAGE_BITS-1:0] ==
        PAGE_BITS'($past(addr_q[PAGE_BITS-1:0]) + 1'b1));
  endproperty
  a_write_incr: assert property (p_write_incr) else $error("write counter not advanced");

  property p_retain;
    @(posedge scl_i) disable iff (rst)
      (state_q == ST_DEV_ACK) |=> $stable(addr_q);
  endproperty
  a_retain: assert property (p_retain) else $error("counter lost on address");

  property p_foreign_refused;
    @(posedge scl_i) disable iff (rst)
      (state_q == ST_DEV && cnt_q == BIT_LAST && !start_pend && !stop_pend
       && rx_byte[7:1] != DEV_ADDR) |=> (state_q == ST_IDLE);
  endproperty
  a_foreign_refused: assert property (p_foreign_refused) else $error("foreign address taken");

  property p_idle_quiet;
    @(posedge scl_i) disable iff (rst)
      (state_q == ST_IDLE) |-> !oe_q;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("line driven while idle");

  property p_byte_mark;
    @(posedge scl_i) disable iff (rst)
      (state_q == ST_RDATA_ACK && !start_pend && !stop_pend)
        |=> (byte_tog_q != $past(byte_tog_q));
  endproperty
  a_byte_mark: assert property (p_byte_mark) else $error("read byte not marked");

endmodule // eeprom_seq_read

// *** tb/two_wire_master.sv ***
// Behavioural two-wire bus master driving the serial clock and data line.
// Assumes the bench resolves the open-drain data line with a pull-up.
`timescale 1ns/1ps
module two_wire_master (
  // Bus lines
  output logic      scl,
  output logic      sda_drv,
  input  wire logic sda_line
);
  // Clock stands high between frames
  initial begin
    scl     = 1'b1;
    sda_drv = 1'b1;
  end

  task automatic start_cond();
    sda_drv = 1'b1;
    #8 scl = 1'b1;
    #15 sda_drv = 1'b0;
    #15 scl = 1'b0;
    #8;
  endtask

  // Stop condition; after the master no-acknowledge it ends a read
  task automatic stop_cond();
    sda_drv = 1'b0;
    #8 scl = 1'b1;
    #15 sda_drv = 1'b1;
    #15;
  endtask

  // One 30 ns clock; sample in the high phase
  task automatic bit_io(input logic b, output logic s);
    sda_drv = b;
    #7 scl = 1'b1;
    #7 s = sda_line;
    #8 scl = 1'b0;
    #8;
  endtask

  // Address, word address or data byte
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s);
    end
    bit_io(1'b1, s);
    ack = ~s;
  endtask

  // Acknowledge continues the burst
  task automatic rd_byte(input logic more, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(~more, s);
  endtask
endmodule // two_wire_master

// *** tb/eeprom_seq_read_tb.sv ***
// Self-checking bench for the serial EEPROM read-side slave.
// Assumes the bus master model drives scl at 30 ns inside frames only.
`timescale 1ns/1ps
module eeprom_seq_read_tb;
  import eeprom_seq_pkg::*;
  logic ref_clk, rst, scl, sda_drv, sda_o, sda_oe, read_busy, read_byte_done;
  wire logic sda_line;
  int err_total, checks_done, cycles, done_cnt;
  localparam logic [7:0] DEV_W = {DEV_ADDR_DEF, 1'b0};
  localparam logic [7:0] DEV_R = {DEV_ADDR_DEF, 1'b1};

  assign sda_line = sda_drv & ~sda_oe;

  eeprom_seq_read u_eeprom_seq_read (.ref_clk(ref_clk), .rst(rst), .scl_i(scl),
    .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe), .read_busy(read_busy),
    .read_byte_done(read_byte_done));

  two_wire_master u_two_wire_master (.scl(scl), .sda_drv(sda_drv), .sda_line(sda_line));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cycles++;
    if (read_byte_done === 1'b1) done_cnt++;
    if (cycles == 5000) begin
      err_total++;
      $display("BAD %0t run did not finish", $time);
      stop_test();
    end
  end

  task automatic stop_test();
    $display("Errors %0d, checks %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wr_pair(input logic [7:0] wa, input logic [7:0] d0, input logic [7:0] d1);
    logic a;
    u_two_wire_master.start_cond();
    u_two_wire_master.wr_byte(DEV_W, a);
    chk({7'h00, a}, 8'h01, "write address ack");
    u_two_wire_master.wr_byte(wa, a);
    chk({7'h00, a}, 8'h01, "word address ack");
    u_two_wire_master.wr_byte(d0, a);
    u_two_wire_master.wr_byte(d1, a);
    chk({7'h00, a}, 8'h01, "data ack");
    u_two_wire_master.stop_cond();
  endtask

  task automatic rd_cur(input logic [7:0] exp);
    logic a;
    logic [7:0] d;
    u_two_wire_master.start_cond();
    u_two_wire_master.wr_byte(DEV_R, a);
    chk({7'h00, a}, 8'h01, "read address ack");
    u_two_wire_master.rd_byte(1'b0, d);
    chk(d, exp, "current address byte");
    chk({7'h00, sda_o}, 8'h00, "pin drive level");
    u_two_wire_master.stop_cond();
  endtask

  task automatic t_seq_wrap();
    logic a, s;
    logic [7:0] d;
    int n0;
    u_two_wire_master.start_cond();
    u_two_wire_master.wr_byte(DEV_W, a);
    u_two_wire_master.wr_byte(8'hFE, a);
    u_two_wire_master.start_cond();
    u_two_wire_master.wr_byte(DEV_R, a);
    chk({7'h00, a}, 8'h01, "random read ack");
    n0 = done_cnt;
    u_two_wire_master.rd_byte(1'b1, d);
    chk(d, 8'hA0, "first byte");
    chk({7'h00, read_busy}, 8'h01, "busy in read");
    u_two_wire_master.rd_byte(1'b1, d);
    chk(d, 8'hA1, "next byte");
    u_two_wire_master.rd_byte(1'b0, d);
    chk(d, 8'h5A, "wrapped byte");
    u_two_wire_master.bit_io(1'b1, s);
    chk({7'h00, s}, 8'h01, "line released after nack");
    u_two_wire_master.stop_cond();
    repeat (6) @(posedge ref_clk);
    #2;
    chk({7'h00, read_busy}, 8'h00, "busy after stop");
    chk(8'(done_cnt - n0), 8'h03, "byte done pulses");
  endtask

  task automatic t_foreign();
    logic a;
    logic [7:0] d;
    u_two_wire_master.start_cond();
    u_two_wire_master.wr_byte(DEV_R ^ 8'h02, a);
    chk({7'h00, a}, 8'h00, "foreign address ack");
    u_two_wire_master.rd_byte(1'b0, d);
    chk(d, 8'hFF, "foreign read line");
    u_two_wire_master.stop_cond();
  endtask

  initial begin
    rst = 1'b1;
    repeat (16) @(posedge ref_clk);
    #2 rst = 1'b0;
    repeat (2) @(posedge ref_clk);
    wr_pair(8'h01, 8'h3C, 8'h77);
    wr_pair(8'h00, 8'h5A, 8'h11);
    rd_cur(8'h77);
    wr_pair(8'hFE, 8'hA0, 8'hA1);
    t_seq_wrap();
    rd_cur(8'h11);
    t_foreign();
    stop_test();
  end
endmodule // eeprom_seq_read_tb
